// ==== exec_cfg.svh ====
// Constants for the interrupt-control, halt and increment execution unit
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
// ----------------------------------------------------------------
// APB byte addresses and register file window select
// ----------------------------------------------------------------
`define A_CMD        12'h000
`define A_STATUS     12'h004
`define A_WGRP       12'h008
`define A_EV_STAT    12'h00C
`define A_EV_MASK    12'h010
`define A_PC         12'h014
`define A_RF_SEL     2'b01
// ----------------------------------------------------------------
// Register file indices of control registers, global enable mask and flag bit positions
// ----------------------------------------------------------------
`define IDX_INT_MASK 8'hFB
`define IDX_FLAGS    8'hFC
`define IDX_STK_LOW  8'hFF
`define GIE_MASK     8'h80
`define FLG_Z        6
`define FLG_S        5
`define FLG_V        4
// ----------------------------------------------------------------
// Opcodes and operand encoding
// ----------------------------------------------------------------
`define OPC_IRQ_OFF  8'h8F
`define OPC_IRQ_ON   8'h9F
`define OPC_HALT     8'h7F
`define OPC_NO_OP    8'hFF
`define OPC_INC_R    8'h20
`define OPC_INC_IR   8'h21
`define OPC_INC_LO   4'hE
`define OPC_WINC_RR  8'hA0
`define OPC_WINC_IR  8'hA1
`define OPC_SRET     8'hBF
`define WREG_NIB     4'hE
// ----------------------------------------------------------------
// Execution lengths, arithmetic constants, events
// ----------------------------------------------------------------
`define CYC_SHORT    5'd6
`define CYC_WORD     5'd10
`define CYC_SRET     5'd16
`define OVF_B        8'h80
`define OVF_W        16'h8000
`define EV_DONE      0
`define EV_HALT      1
`define EV_WAKE      2
`define EV_BAD       3
`define EV_W         4
`endif

// ==== exec_pkg.sv ====
// Types shared by the execution unit
`default_nettype none
package exec_pkg;
  typedef struct packed {
    logic [7:0] operand;
    logic [7:0] opcode;
  } instr_s;
  typedef enum logic [3:0] {
    no_operation_op, global_irq_off_op, global_irq_on_op, halt_op,
    byte_increment_op, word_increment_op, service_return_op, bad_op
  } op_kind_e;
  typedef enum logic [1:0] {st_idle, st_exec, st_halt} state_e;
endpackage : exec_pkg
`default_nettype wire

// ==== intctl_halt_increment_exec.sv ====
// Execution unit for interrupt control, halt, increments and service return
// Function
// - Global interrupt off opcode clears bit 7 of interrupt mask at FBh.
// - Per-level enable bits of the interrupt mask stay untouched.
// - Global interrupt on opcode sets bit 7 of interrupt mask.
// - Halt stops the core clock; the oscillator keeps running.
// - Timers and three external interrupt inputs keep working while halted.
// - Any external or internal interrupt request ends the halted state.
// - Byte increment adds one to the addressed operand and writes it back.
// - Increments set zero and sign from result; carry, decimal-adjust and half-carry unchanged.
// - Increments set overflow on signed overflow, else clear it.
// - Operand high nibble Eh selects a working register in current group.
// - Word increment works on an even-addressed pair as one 16-bit value.
// - Service return pops flags, then program counter high first; stack advances three.
// - Service return sets the global interrupt enable at its end.
// - Stack pointer low byte lives in control register FFh.
//
// The APB slave port was decided locally.
`include "exec_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module intctl_halt_increment_exec
  import exec_pkg::*;
#(
  parameter int RF_ADDR_W = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Interrupt sources
  input  wire logic        ext_interrupt_one,
  input  wire logic        ext_interrupt_two,
  input  wire logic        ext_interrupt_three,
  input  wire logic        timer_irq,
  // Core clock control and interrupt output
  output logic             core_clk_run,
  output logic             irq
);
  localparam int RF_DEPTH = 2 ** RF_ADDR_W;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (RF_ADDR_W != 8) begin : g_bad_width
    $error("RF_ADDR_W must be 8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]       rf_mem [RF_DEPTH];
  state_e           state_reg;
  instr_s           instr_reg;
  op_kind_e         kind_reg;
  op_kind_e         kind_next;
  logic [4:0]       cnt_reg;
  logic [15:0]      pc_reg;
  logic [3:0]       wgrp_reg;
  logic [`EV_W-1:0] ev_stat_reg;
  logic [`EV_W-1:0] ev_mask_reg;
  logic [`EV_W-1:0] ev_set;
  logic [2:0]       ext_meta_reg;
  logic [2:0]       ext_sync_reg;
  logic [31:0]      prdata_reg;
  logic             pslverr_reg;
  logic             setup_ph;
  logic             wr_acc;
  logic             accept;
  logic             done;
  logic             wake_any;
  logic             rf_hit;
  logic [7:0]       rf_idx;
  logic [7:0]       wa;
  logic [7:0]       ba;
  logic [7:0]       pbase;
  logic [7:0]       pa;
  logic [7:0]       pb;
  logic [7:0]       stk;
  logic [7:0]       stk1;
  logic [7:0]       stk2;
  logic [7:0]       stk3;
  logic [7:0]       byte_res;
  logic [15:0]      word_res;
  logic [7:0]       flags_b;
  logic [7:0]       flags_w;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Access phases complete at once; data and error were captured in setup
  assign pready   = 1'b1;
  assign prdata   = prdata_reg;
  assign pslverr  = pslverr_reg;
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & ~pslverr_reg;
  assign rf_hit   = (paddr[11:10] == `A_RF_SEL);
  assign rf_idx   = paddr[9:2];
  assign accept   = wr_acc & (paddr == `A_CMD);

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      if (rf_hit) begin
        prdata_reg <= {24'h00_0000, rf_mem[rf_idx]};
      end else begin
        case (paddr)
          `A_CMD: begin
            prdata_reg  <= {16'h0000, instr_reg};
            pslverr_reg <= pwrite & (state_reg != st_idle); // Busy or halted
          end
          `A_STATUS:  prdata_reg <= {30'h0, state_reg == st_halt, state_reg == st_exec};
          `A_WGRP:    prdata_reg <= {24'h00_0000, wgrp_reg, 4'h0};
          `A_EV_STAT: prdata_reg <= {28'h000_0000, ev_stat_reg};
          `A_EV_MASK: prdata_reg <= {28'h000_0000, ev_mask_reg};
          `A_PC:      prdata_reg <= {16'h0000, pc_reg};
          default:    pslverr_reg <= 1'b1;
        endcase
      end
    end
  end

  // Working register group and event mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wgrp_reg    <= 4'h0;
      ev_mask_reg <= 4'h0;
    end else if (wr_acc) begin
      if (paddr == `A_WGRP) wgrp_reg <= pwdata[7:4];
      if (paddr == `A_EV_MASK) ev_mask_reg <= pwdata[`EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------------
  // External pins pass two flops; they run whether or not the core is halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
    end else begin
      ext_meta_reg <= {ext_interrupt_three, ext_interrupt_two, ext_interrupt_one};
      ext_sync_reg <= ext_meta_reg;
    end
  end

  assign wake_any = (|ext_sync_reg) | timer_irq;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  // Kind of a newly issued opcode
  always_comb begin
    kind_next = bad_op;
    case (pwdata[7:0])
      `OPC_IRQ_OFF: kind_next = global_irq_off_op;
      `OPC_IRQ_ON:  kind_next = global_irq_on_op;
      `OPC_HALT:    kind_next = halt_op;
      `OPC_NO_OP:   kind_next = no_operation_op;
      `OPC_INC_R:   kind_next = byte_increment_op;
      `OPC_INC_IR:  kind_next = byte_increment_op;
      `OPC_WINC_RR: kind_next = word_increment_op;
      `OPC_WINC_IR: kind_next = word_increment_op;
      `OPC_SRET:    kind_next = service_return_op;
      default: begin
        if (pwdata[3:0] == `OPC_INC_LO) kind_next = byte_increment_op;
      end
    endcase
  end

  // Execution lengths
  function automatic logic [4:0] cycles_of(input op_kind_e k);
    case (k)
      word_increment_op: cycles_of = `CYC_WORD;
      service_return_op: cycles_of = `CYC_SRET;
      default:           cycles_of = `CYC_SHORT;
    endcase
  endfunction : cycles_of

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign done = (state_reg == st_exec) && (cnt_reg == 5'd0);

  // Issue, count down, halt and wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_idle;
      instr_reg <= 16'h0000;
      kind_reg  <= no_operation_op;
      cnt_reg   <= 5'd0;
    end else begin
      case (state_reg)
        st_idle: begin
          if (accept) begin
            instr_reg <= pwdata[15:0];
            kind_reg  <= kind_next;
            cnt_reg   <= cycles_of(kind_next) - 5'd1;
            state_reg <= st_exec;
          end
        end
        st_exec: begin
          if (cnt_reg != 5'd0) begin
            cnt_reg <= cnt_reg - 5'd1;
          end else if (kind_reg == halt_op) begin
            state_reg <= st_halt;
          end else begin
            state_reg <= st_idle;
          end
        end
        st_halt: begin
          if (wake_any) state_reg <= st_idle;
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // Core clock enable; the oscillator itself is never gated
  assign core_clk_run = (state_reg != st_halt);

  // ----------------------------------------------------------------
  // Operand addressing and arithmetic
  // ----------------------------------------------------------------
  // Working register form maps low nibble into the current group
  assign wa = (instr_reg.operand[7:4] == `WREG_NIB) ?
              {wgrp_reg, instr_reg.operand[3:0]} : instr_reg.operand;

  // Byte destination: short form, direct or indirect
  always_comb begin
    ba = rf_mem[wa];
    if (instr_reg.opcode == `OPC_INC_R) ba = wa;
    else if (instr_reg.opcode[3:0] == `OPC_INC_LO)
      ba = {wgrp_reg, instr_reg.opcode[7:4]};
  end

  // Pair destination forced even, high byte at the even address
  assign pbase    = (instr_reg.opcode == `OPC_WINC_RR) ? wa : rf_mem[wa];
  assign pa       = {pbase[7:1], 1'b0};
  assign pb       = {pbase[7:1], 1'b1};
  assign byte_res = rf_mem[ba] + 8'h01;
  assign word_res = {rf_mem[pa], rf_mem[pb]} + 16'h0001;

  // Flag images; carry, decimal-adjust and half-carry kept
  always_comb begin
    flags_b = rf_mem[`IDX_FLAGS];
    flags_b[`FLG_Z] = (byte_res == 8'h00);
    flags_b[`FLG_S] = byte_res[7];
    flags_b[`FLG_V] = (byte_res == `OVF_B);
    flags_w = rf_mem[`IDX_FLAGS];
    flags_w[`FLG_Z] = (word_res == 16'h0000);
    flags_w[`FLG_S] = word_res[15];
    flags_w[`FLG_V] = (word_res == `OVF_W);
  end

  // Stack addresses from the stack pointer low byte
  assign stk  = rf_mem[`IDX_STK_LOW];
  assign stk1 = stk + 8'd1;
  assign stk2 = stk + 8'd2;
  assign stk3 = stk + 8'd3;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Software writes first; an opcode finishing in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RF_DEPTH; i++) rf_mem[i] <= 8'h00;
    end else begin
      if (wr_acc && rf_hit) rf_mem[rf_idx] <= pwdata[7:0];
      if (done) begin
        case (kind_reg)
          global_irq_off_op: rf_mem[`IDX_INT_MASK] <=
            rf_mem[`IDX_INT_MASK] & ~`GIE_MASK;
          global_irq_on_op:  rf_mem[`IDX_INT_MASK] <= rf_mem[`IDX_INT_MASK] | `GIE_MASK;
          byte_increment_op: begin
            rf_mem[ba]         <= byte_res;
            rf_mem[`IDX_FLAGS] <= flags_b;
          end
          word_increment_op: begin
            rf_mem[pa]         <= word_res[15:8];
            rf_mem[pb]         <= word_res[7:0];
            rf_mem[`IDX_FLAGS] <= flags_w;
          end
          service_return_op: begin
            rf_mem[`IDX_FLAGS]    <= rf_mem[stk];
            rf_mem[`IDX_STK_LOW]  <= stk3;
            rf_mem[`IDX_INT_MASK] <= rf_mem[`IDX_INT_MASK] | `GIE_MASK;
          end
          default: ;
        endcase
      end
    end
  end

  // Program counter restored high byte first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pc_reg <= 16'h0000;
    else if (done && kind_reg == service_return_op) pc_reg <= {rf_mem[stk1], rf_mem[stk2]};
  end

  // ----------------------------------------------------------------
  // Events and interrupt output
  // ----------------------------------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[`EV_DONE] = done;
    ev_set[`EV_HALT] = done && (kind_reg == halt_op);
    ev_set[`EV_WAKE] = (state_reg == st_halt) && wake_any;
    ev_set[`EV_BAD]  = done && (kind_reg == bad_op);
  end

  // Sticky status, write one to clear, a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ev_stat_reg <= '0;
    else if (wr_acc && paddr == `A_EV_STAT)
      ev_stat_reg <= (ev_stat_reg & ~pwdata[`EV_W-1:0]) | ev_set;
    else ev_stat_reg <= ev_stat_reg | ev_set;
  end

  assign irq = |(ev_stat_reg & ev_mask_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_gie_off_done: assert property (@(posedge pclk) disable iff (!presetn)
    done && kind_reg == global_irq_off_op |=> !rf_mem[`IDX_INT_MASK][7])
    else $error("global enable not cleared");
  a_level_bits_kept: assert property (@(posedge pclk) disable iff (!presetn)
    done && kind_reg == global_irq_off_op |=>
      rf_mem[`IDX_INT_MASK][6:0] == $past(rf_mem[`IDX_INT_MASK][6:0]))
    else $error("level enables changed");
  a_gie_on_done: assert property (@(posedge pclk) disable iff (!presetn)
    done && kind_reg == global_irq_on_op |=> rf_mem[`IDX_INT_MASK][7])
    else $error("global enable not set");
  a_halt_clk_off: assert property (@(posedge pclk) disable iff (!presetn)
    done && kind_reg == halt_op |=> !core_clk_run)
    else $error("core clock still running after halt");
  a_wake_clk_on: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == st_halt && wake_any |=> core_clk_run && ev_stat_reg[`EV_WAKE])
    else $error("no wake on interrupt");
  a_ext_pin_wake: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == st_halt && ext_interrupt_two ##1 ext_interrupt_two |=> ##[0:1] core_clk_run)
    else $error("external pin ignored while halted");
  a_inc_flags: assert property (@(posedge pclk) disable iff (!presetn)
    done && kind_reg == byte_increment_op && ba != `IDX_FLAGS |=>
      rf_mem[`IDX_FLAGS][`FLG_Z] == ($past(rf_mem[ba]) == 8'hFF) &&
      rf_mem[`IDX_FLAGS][7] == $past(rf_mem[`IDX_FLAGS][7]))
    else $error("increment zero or carry flag wrong");
  a_inc_ovf: assert property (@(posedge pclk) disable iff (!presetn)
    done && kind_reg == byte_increment_op && ba != `IDX_FLAGS |=>
      rf_mem[`IDX_FLAGS][`FLG_V] == ($past(rf_mem[ba]) == 8'h7F))
    else $error("increment overflow flag wrong");
  a_sret_stack: assert property (@(posedge pclk) disable iff (!presetn)
    done && kind_reg == service_return_op |=>
      rf_mem[`IDX_STK_LOW] == $past(rf_mem[`IDX_STK_LOW]) + 8'd3 && rf_mem[`IDX_INT_MASK][7])
    else $error("service return stack or enable wrong");
  a_word_len: assert property (@(posedge pclk) disable iff (!presetn)
    accept && kind_next == word_increment_op |=>
      (state_reg == st_exec)[*8] ##1 !done ##1 done)
    else $error("word increment length wrong");

endmodule : intctl_halt_increment_exec
`default_nettype wire

// ==== test_intctl_halt_increment_exec.sv ====
// Self-checking testbench for the interrupt-control, halt and increment execution unit
`include "exec_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module test_intctl_halt_increment_exec import exec_pkg::*;;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        ext_interrupt_one;
  logic        ext_interrupt_two;
  logic        ext_interrupt_three;
  logic        timer_irq;
  logic        core_clk_run;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          bad_count;
  int          tests_run;
  int          cyc;

  // Unit under test
  intctl_halt_increment_exec #(.RF_ADDR_W(8)) i_intctl_halt_increment_exec (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_interrupt_one(ext_interrupt_one), .ext_interrupt_two(ext_interrupt_two),
    .ext_interrupt_three(ext_interrupt_three), .timer_irq(timer_irq),
    .core_clk_run(core_clk_run), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Cut a hung run short after far more cycles than the tests need
  initial begin
    cyc = 0;
    forever begin
      @(posedge pclk);
      cyc++;
      if (cyc == 12000) begin
        bad_count++;
        stop_test();
      end
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Compare one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register file byte access
  task automatic rf_wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, {`A_RF_SEL, idx, 2'b00}, {24'h0, v});
  endtask : rf_wr

  task automatic rf_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, {`A_RF_SEL, idx, 2'b00}, 32'h0);
    check(rd, {24'h0, exp});
  endtask : rf_chk

  // Poll status until the unit is idle; it must report busy at first
  task automatic wait_idle();
    int n;
    apb(1'b0, `A_STATUS, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    n = 0;
    while (rd[0] !== 1'b0 && n < 40) begin
      apb(1'b0, `A_STATUS, 32'h0);
      n++;
    end
    check({31'h0, rd[0]}, 32'h0);
  endtask : wait_idle

  task automatic exec(input logic [7:0] op, input logic [7:0] opnd);
    apb(1'b1, `A_CMD, {16'h0, opnd, op});
    wait_idle();
  endtask : exec

  // Expected flags: carry, decimal and half-carry kept
  function automatic logic [7:0] fexp(input logic [7:0] f, input logic z, input logic s,
                                      input logic v);
    return {f[7], z, s, v, f[3:0]};
  endfunction : fexp

  task automatic inc_b(input logic [7:0] op, input logic [7:0] opnd, input logic [7:0] a,
                       input logic [7:0] v, input logic [7:0] pre);
    logic [7:0] r;
    r = v + 8'h01;
    rf_wr(a, v);
    rf_wr(`IDX_FLAGS, pre);
    exec(op, opnd);
    rf_chk(a, r);
    rf_chk(`IDX_FLAGS, fexp(pre, r == 8'h00, r[7], v == 8'h7F));
  endtask : inc_b

  task automatic inc_w(input logic [7:0] op, input logic [7:0] opnd, input logic [7:0] a,
                       input logic [15:0] w, input logic [7:0] pre);
    logic [15:0] r;
    r = w + 16'h0001;
    rf_wr(a, w[15:8]);
    rf_wr(a + 8'h01, w[7:0]);
    rf_wr(`IDX_FLAGS, pre);
    exec(op, opnd);
    rf_chk(a, r[15:8]);
    rf_chk(a + 8'h01, r[7:0]);
    rf_chk(`IDX_FLAGS, fexp(pre, r == 16'h0, r[15], w == 16'h7FFF));
  endtask : inc_w

  // Halt after a no-op, then wake from source k
  task automatic halt_wake(input int k);
    int n;
    exec(`OPC_NO_OP, 8'h00);
    apb(1'b1, `A_EV_STAT, 32'hF);
    apb(1'b1, `A_CMD, {24'h0, `OPC_HALT});
    n = 0;
    while (core_clk_run !== 1'b0 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check(n, 32'(`CYC_SHORT));
    apb(1'b0, `A_STATUS, 32'h0);
    check({31'h0, rd[1]}, 32'h1);
    apb(1'b1, `A_CMD, {24'h0, `OPC_IRQ_ON});
    check({31'h0, er}, 32'h1);
    check({31'h0, core_clk_run}, 32'h0);
    case (k)
      0: ext_interrupt_one <= 1'b1;
      1: ext_interrupt_two <= 1'b1;
      2: ext_interrupt_three <= 1'b1;
      default: timer_irq <= 1'b1;
    endcase
    n = 0;
    while (core_clk_run !== 1'b1 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check({31'h0, core_clk_run}, 32'h1);
    {ext_interrupt_one, ext_interrupt_two, ext_interrupt_three, timer_irq} <= 4'h0;
    apb(1'b0, `A_STATUS, 32'h0);
    check({31'h0, rd[1]}, 32'h0);
    apb(1'b0, `A_EV_STAT, 32'h0);
    check({29'h0, rd[2:0]}, 32'h7);
  endtask : halt_wake

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    tests_run = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_interrupt_one, ext_interrupt_two, ext_interrupt_three, timer_irq} = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state and an unmapped address
    rf_chk(`IDX_INT_MASK, 8'h00);
    rf_chk(`IDX_FLAGS, 8'h00);
    rf_chk(`IDX_STK_LOW, 8'h00);
    apb(1'b0, 12'h200, 32'h0);
    check({er, rd[30:0]}, 32'h8000_0000);
    // Global enable on and off; per-level bits stay
    for (int i = 0; i < 2; i++) begin
      rf_wr(`IDX_INT_MASK, i == 0 ? 8'h0A : 8'h75);
      exec(`OPC_IRQ_ON, 8'h00);
      rf_chk(`IDX_INT_MASK, i == 0 ? 8'h8A : 8'hF5);
      exec(`OPC_IRQ_OFF, 8'h00);
      rf_chk(`IDX_INT_MASK, i == 0 ? 8'h0A : 8'h75);
    end
    // A command while busy is refused
    apb(1'b1, `A_CMD, {24'h0, `OPC_IRQ_ON});
    apb(1'b1, `A_CMD, {24'h0, `OPC_IRQ_OFF});
    check({31'h0, er}, 32'h1);
    wait_idle();
    rf_chk(`IDX_INT_MASK, 8'hF5);
    // Byte increments: direct, working register, indirect
    apb(1'b1, `A_WGRP, 32'h20);
    rf_wr(8'h20, 8'h30);
    rf_wr(8'h25, 8'h60);
    inc_b(`OPC_INC_R, 8'hB3, 8'hB3, 8'h2A, 8'hFC);
    inc_b(`OPC_INC_R, 8'hB3, 8'hB3, 8'h7F, 8'h00);
    inc_b(`OPC_INC_R, 8'hB3, 8'hB3, 8'hFF, 8'hFC);
    inc_b({4'hA, `OPC_INC_LO}, 8'h00, 8'h2A, 8'hCB, 8'h00);
    inc_b(`OPC_INC_R, 8'hEA, 8'h2A, 8'h2A, 8'hFC);
    rf_wr(8'hB3, 8'hCB);
    inc_b(`OPC_INC_IR, 8'hB3, 8'hCB, 8'hFF, 8'h00);
    inc_b(`OPC_INC_IR, 8'hE5, 8'h60, 8'h80, 8'hFC);
    // Word increments on pairs
    inc_w(`OPC_WINC_RR, 8'h30, 8'h30, 16'h0AF2, 8'h00);
    inc_w(`OPC_WINC_IR, 8'hE0, 8'h30, 16'hFAF3, 8'hFC);
    inc_w(`OPC_WINC_RR, 8'hE6, 8'h26, 16'h7FFF, 8'h00);
    inc_w(`OPC_WINC_RR, 8'h30, 8'h30, 16'hFFFF, 8'hFC);
    // Service return from a stack at 45h
    rf_wr(`IDX_STK_LOW, 8'h45);
    rf_wr(8'h45, 8'h00);
    rf_wr(8'h46, 8'h6F);
    rf_wr(8'h47, 8'hE4);
    rf_wr(`IDX_INT_MASK, 8'h0A);
    rf_wr(`IDX_FLAGS, 8'hFF);
    exec(`OPC_SRET, 8'h00);
    rf_chk(`IDX_FLAGS, 8'h00);
    rf_chk(`IDX_STK_LOW, 8'h48);
    rf_chk(`IDX_INT_MASK, 8'h8A);
    apb(1'b0, `A_PC, 32'h0);
    check(rd, 32'h0000_6FE4);
    // Event status, mask and interrupt line; unknown opcode event
    apb(1'b1, `A_EV_STAT, 32'hF);
    apb(1'b1, `A_EV_MASK, 32'h1);
    check({31'h0, irq}, 32'h0);
    exec(8'h55, 8'h00);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, `A_EV_STAT, 32'h0);
    check({28'h0, rd[3:0]}, 32'h9);
    apb(1'b1, `A_EV_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `A_EV_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `A_EV_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    // Halt and wake from every interrupt source
    for (int k = 0; k < 4; k++) begin
      halt_wake(k);
    end
    stop_test();
  end
endmodule : test_intctl_halt_increment_exec
`default_nettype wire
